/* fault_if.sv */
// Fault source and latched status between the top and a fault latch
`timescale 1ns/1ps
interface fault_if;
    logic src;     // Raw combined fault condition
    logic active;  // Fault state, held and latched
    logic rise;    // One-cycle pulse on fault entry
    modport latch (input src, output active, output rise);
    modport user  (output src, input active, input rise);
endinterface // fault_if

/* fault_latch.sv */
// Holds a combined fault for a fixed time, then until the source clears
`timescale 1ns/1ps
`include "half_bridge_map.svh"
module fault_latch #(
    parameter int unsigned LATCH_CYC = `HB_LATCH_CYC,  // Hold time, cycles
    parameter int unsigned CNT_W     = `HB_LATCH_W     // Hold counter width
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clkEn,
    fault_if.latch    flt
);
    localparam logic [CNT_W-1:0] HOLD_M1 = CNT_W'(LATCH_CYC - 1);

    logic [CNT_W-1:0] holdQ;    // Remaining hold cycles
    logic             activeQ;  // Fault state
    logic             riseQ;    // Entry pulse

    // Enter on source, hold the full time, leave once source is gone
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            holdQ   <= '0;
            activeQ <= 1'b0;
            riseQ   <= 1'b0;
        end
        else if (clkEn)
        begin
            riseQ <= flt.src & ~activeQ;
            if (!activeQ)
            begin
                if (flt.src)
                begin
                    activeQ <= 1'b1;
                    holdQ   <= HOLD_M1;
                end
            end
            else if (holdQ != '0)
                holdQ <= holdQ - 1'b1;
            else if (!flt.src)
                activeQ <= 1'b0;
        end
    end

    assign flt.active = activeQ;
    assign flt.rise   = riseQ;
endmodule // fault_latch

/* glitch_filter.sv */
// Minimum pulse width filter for one command input
`timescale 1ns/1ps
module glitch_filter #(
    parameter int unsigned WIDTH = 13  // Least accepted pulse, cycles
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clkEn,
    input  wire logic raw,
    output logic      filtered
);
    localparam int unsigned CW = $clog2(WIDTH + 1);
    localparam logic [CW-1:0] LAST = CW'(WIDTH - 1);

    logic [CW-1:0] cntQ;  // Cycles the input has differed
    logic          outQ;  // Accepted level

    // Accept a new level only after it stood WIDTH cycles
    // drop short pulses
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cntQ <= '0;
            outQ <= 1'b0;
        end
        else if (clkEn)
        begin
            if (raw == outQ)
                cntQ <= '0;
            else if (cntQ == LAST)
            begin
                outQ <= raw;
                cntQ <= '0;
            end
            else
                cntQ <= cntQ + 1'b1;
        end
    end

    assign filtered = outQ;
endmodule // glitch_filter

/* half_bridge_gating.sv */
// Fault aggregation, latching and PWM gating of a half-bridge driver
`timescale 1ns/1ps
`include "half_bridge_map.svh"
module half_bridge_gating #(
    parameter int unsigned LATCH_CYC  = `HB_LATCH_CYC,   // Fault hold
    parameter int unsigned GLITCH_CYC = `HB_GLITCH_CYC,  // Filter width
    parameter int unsigned AOV_CYC    = `HB_AOV_CYC,     // Overlap limit
    parameter int unsigned NOV_CYC    = `HB_NOV_CYC,     // Dead time
    parameter int unsigned BLANK_CYC  = `HB_BLANK_CYC    // Desat blanking
) (
    input  wire logic clk,                       // Board clock
    input  wire logic rst_n,                     // Power-on reset
    input  wire logic clkEn,                     // Freezes state when low
    input  wire logic low_cmd_in,                // Low-side command
    input  wire logic high_cmd_in,               // High-side command
    input  wire logic primUndervoltageLockout,   // Main supply too low
    input  wire logic primPowerGood,             // Primary regulator good
    input  wire logic lowUndervoltageLockout,    // Low channel supply low
    input  wire logic lowPowerGood,              // Low regulator good
    input  wire logic low_drain_sense,           // Low desat comparator
    input  wire logic highUndervoltageLockout,   // High channel supply low
    input  wire logic highPowerGood,             // High regulator good
    input  wire logic highDrainSense,            // High desat comparator
    input  wire logic mode_strap,                // Strap installed = local
    input  wire logic lowFaultNIn,               // Low fault pin level
    input  wire logic highFaultNIn,              // High fault pin level
    output logic      low_gate_out,              // Low-side gate command
    output logic      high_gate_out,             // High-side gate command
    output logic      lowSoftOff,                // Low soft shutdown
    output logic      highSoftOff,               // High soft shutdown
    output logic      lowFaultNOut,              // Low fault pin value
    output logic      lowFaultNOe,               // Low fault pin drive
    output logic      highFaultNOut,             // High fault pin value
    output logic      highFaultNOe,              // High fault pin drive
    output logic      converterEnable,           // DC-DC converter on
    output logic      power_indicator,           // Green indicator
    output logic      fault_indicator            // Red indicator
);
    localparam int unsigned AOV_W   = $clog2(AOV_CYC + 1);
    localparam int unsigned NOV_W   = $clog2(NOV_CYC + 1);
    localparam int unsigned BLANK_W = $clog2(BLANK_CYC + 1);
    localparam logic [NOV_W-1:0]   NOV_END   = NOV_W'(NOV_CYC);
    localparam logic [AOV_W-1:0]   AOV_END   = AOV_W'(AOV_CYC);
    localparam logic [BLANK_W-1:0] BLANK_END = BLANK_W'(BLANK_CYC);

    // Mode capture after reset release
    half_bridge_pkg::mode_e modeQ;      // Captured mode
    logic                   capturedQ;  // Mode has been taken

    // Filtered command inputs
    logic filtLow;   // Low input after filter
    logic filtHigh;  // High input after filter

    // Per-channel signals, index 0 low, 1 high
    logic [1:0] want;       // Requested gate level after mode logic
    logic [1:0] wantPrevQ;  // Previous request, edge detection
    logic [1:0] cmdRise;    // Request rising edge
    logic [1:0] go;         // Request after dead time
    logic [1:0] gateQ;      // Gate outputs
    logic [1:0] softQ;      // Soft shutdown outputs
    logic [1:0] faultOeQ;   // Fault pin drive
    logic [1:0] faultOutQ;  // Fault pin value
    logic [1:0] desatSeen;  // Desat after blanking
    logic [1:0] drainSense; // Desat comparator per channel
    logic [1:0] chUvlo;     // Channel undervoltage
    logic [1:0] chPgood;    // Channel regulator good
    logic [1:0] chActive;   // Channel fault state
    logic [1:0] chRise;     // Channel fault entry

    // Direct mode overlap guard
    logic [AOV_W-1:0] ovCntQ;  // Cycles both inputs high
    logic             lockQ;   // Both gates forced low

    // Aggregate outputs
    logic convEnQ;   // Converter enable
    logic powerQ;    // Green indicator
    logic faultIndQ; // Red indicator

    // Fault latch carriers
    fault_if primIf ();
    fault_if chIf [2] ();

    assign drainSense = {highDrainSense, low_drain_sense};
    assign chUvlo     = {highUndervoltageLockout, lowUndervoltageLockout};
    assign chPgood    = {highPowerGood, lowPowerGood};

    // Low input filter, used in direct mode only
    // filter both in direct
    glitch_filter #(
        .WIDTH (GLITCH_CYC)
    ) u_filt_low (
        .clk      (clk),
        .rst_n    (rst_n),
        .clkEn    (clkEn),
        .raw      (low_cmd_in),
        .filtered (filtLow)
    );

    // High input filter, used in both modes
    // filter high input
    glitch_filter #(
        .WIDTH (GLITCH_CYC)
    ) u_filt_high (
        .clk      (clk),
        .rst_n    (rst_n),
        .clkEn    (clkEn),
        .raw      (high_cmd_in),
        .filtered (filtHigh)
    );

    // Primary fault source
    // OR of both sources
    assign primIf.src = primUndervoltageLockout | ~primPowerGood;

    fault_latch #(
        .LATCH_CYC (LATCH_CYC),
        .CNT_W     (`HB_LATCH_W)
    ) u_prim_latch (
        .clk   (clk),
        .rst_n (rst_n),
        .clkEn (clkEn),
        .flt   (primIf)
    );

    // Strap caught once, at the first enabled edge after release
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            modeQ     <= half_bridge_pkg::MODE_DIRECT;
            capturedQ <= 1'b0;
        end
        else if (clkEn && !capturedQ)
        begin
            modeQ     <= mode_strap ? half_bridge_pkg::MODE_LOCAL
                                    : half_bridge_pkg::MODE_DIRECT;
            capturedQ <= 1'b1;
        end
    end

    // Overlap guard: both inputs high too long forces both gates low
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ovCntQ <= '0;
            lockQ  <= 1'b0;
        end
        else if (clkEn)
        begin
            if (!(filtLow && filtHigh))
            begin
                ovCntQ <= '0;
                lockQ  <= 1'b0;
            end
            else if (ovCntQ == AOV_END)
                lockQ  <= 1'b1;
            else
                ovCntQ <= ovCntQ + 1'b1;
        end
    end

    // Requested gate levels per mode
    always_comb
    begin
        if (modeQ == half_bridge_pkg::MODE_LOCAL)
        begin
            // low on while high input low
            want[0] = ~filtHigh;
            want[1] = filtHigh;
        end
        else
        begin
            want[0] = filtLow & ~lockQ;
            want[1] = filtHigh & ~lockQ;
        end
    end

    // Request edge detection for re-arming
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wantPrevQ <= 2'h0;
        else if (clkEn)
            wantPrevQ <= capturedQ ? want : 2'h3;
    end

    assign cmdRise = want & ~wantPrevQ;

    // Per-channel dead time, blanking, fault latch and gating state
    for (genvar i = 0; i < 2; i++)
    begin : g_ch
        logic [NOV_W-1:0]          delCntQ;    // Cycles request stood
        logic [BLANK_W-1:0]        blankCntQ;  // Cycles gate has been on
        half_bridge_pkg::ch_state_e stateQ;    // Gating state
        half_bridge_pkg::ch_state_e stateD;    // Next gating state

        // Turn-on waits out the dead time, turn-off is immediate
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                delCntQ <= '0;
            else if (clkEn)
            begin
                if (!want[i])
                    delCntQ <= '0;
                else if (delCntQ != NOV_END)
                    delCntQ <= delCntQ + 1'b1;
            end
        end

        assign go[i] = want[i] && (delCntQ == NOV_END);

        // Blanking counter restarts on each gate turn-on
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                blankCntQ <= '0;
            else if (clkEn)
            begin
                if (!gateQ[i])
                    blankCntQ <= '0;
                else if (blankCntQ != BLANK_END)
                    blankCntQ <= blankCntQ + 1'b1;
            end
        end

        assign desatSeen[i] = drainSense[i] && (blankCntQ == BLANK_END);

        assign chIf[i].src = chUvlo[i] | ~chPgood[i] | desatSeen[i];

        fault_latch #(
            .LATCH_CYC (LATCH_CYC),
            .CNT_W     (`HB_LATCH_W)
        ) u_ch_latch (
            .clk   (clk),
            .rst_n (rst_n),
            .clkEn (clkEn),
            .flt   (chIf[i])
        );

        assign chActive[i] = chIf[i].active;
        assign chRise[i]   = chIf[i].rise;

        // Next gating state
        always_comb
        begin
            stateD = stateQ;
            if (primIf.active || !capturedQ)
                stateD = half_bridge_pkg::CH_BLOCKED;
            else if (chRise[i])
                stateD = half_bridge_pkg::CH_SOFT;
            else
            begin
                unique case (stateQ)
                    // Waiting for a fresh command edge
                    half_bridge_pkg::CH_BLOCKED:
                        if (cmdRise[i] && !chActive[i])
                            stateD = half_bridge_pkg::CH_RUN;
                    // Following the command
                    half_bridge_pkg::CH_RUN:
                        if (chActive[i])
                            stateD = half_bridge_pkg::CH_SOFT;
                    // Gate held off softly while faulted
                    half_bridge_pkg::CH_SOFT:
                        if (!chActive[i])
                            stateD = half_bridge_pkg::CH_BLOCKED;
                    // Unused code recovers to blocked
                    default:
                        stateD = half_bridge_pkg::CH_BLOCKED;
                endcase
            end
        end

        // Gating state and soft shutdown output
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                stateQ   <= half_bridge_pkg::CH_BLOCKED;
                softQ[i] <= 1'b0;
            end
            else if (clkEn)
            begin
                stateQ   <= stateD;
                softQ[i] <= (stateD == half_bridge_pkg::CH_SOFT);
            end
        end

        // Fault pin: driven low on primary or own channel fault
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                faultOeQ[i]  <= 1'b0;
                faultOutQ[i] <= 1'b1;
            end
            else if (clkEn)
            begin
                faultOeQ[i]  <= primIf.active | chActive[i];
                faultOutQ[i] <= ~(primIf.active | chActive[i]);
            end
        end
    end

    // Gate registers; the other gate must be off before one turns on
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            gateQ <= 2'h0;
        else if (clkEn)
        begin
            gateQ[0] <= (g_ch[0].stateD == half_bridge_pkg::CH_RUN)
                        & go[0] & ~gateQ[1];
            // Low side wins a same-cycle tie
            gateQ[1] <= (g_ch[1].stateD == half_bridge_pkg::CH_RUN)
                        & go[1] & ~gateQ[0] & ~go[0];
        end
    end

    // Converter enable and status indicators
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            convEnQ   <= 1'b0;
            powerQ    <= 1'b0;
            faultIndQ <= 1'b0;
        end
        else if (clkEn)
        begin
            convEnQ   <= ~primIf.active;
            // green on, red on any fault
            powerQ    <= 1'b1;
            faultIndQ <= primIf.active | (|chActive);
        end
    end

    // Outputs straight from flip-flops
    assign low_gate_out    = gateQ[0];
    assign high_gate_out   = gateQ[1];
    assign lowSoftOff      = softQ[0];
    assign highSoftOff     = softQ[1];
    assign lowFaultNOe     = faultOeQ[0];
    assign lowFaultNOut    = faultOutQ[0];
    assign highFaultNOe    = faultOeQ[1];
    assign highFaultNOut   = faultOutQ[1];
    assign converterEnable = convEnQ;
    assign power_indicator = powerQ;
    assign fault_indicator = faultIndQ;
endmodule // half_bridge_gating

/* half_bridge_gating_sva.sv */
// Concurrent checks on the ports of the half-bridge gating block
`timescale 1ns/1ps
module half_bridge_gating_sva #(
    parameter int unsigned LATCH_CYC  = 200,  // Fault hold, cycles
    parameter int unsigned GLITCH_CYC = 3,    // Filter width, cycles
    parameter int unsigned NOV_CYC    = 4     // Dead time, cycles
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic low_cmd_in,
    input wire logic mode_strap,
    input wire logic primUndervoltageLockout,
    input wire logic primPowerGood,
    input wire logic lowUndervoltageLockout,
    input wire logic lowPowerGood,
    input wire logic low_gate_out,
    input wire logic high_gate_out,
    input wire logic lowSoftOff,
    input wire logic highSoftOff,
    input wire logic lowFaultNOut,
    input wire logic lowFaultNOe,
    input wire logic highFaultNOut,
    input wire logic highFaultNOe,
    input wire logic converterEnable,
    input wire logic power_indicator,
    input wire logic fault_indicator
);
    logic [31:0] holdCnt_q;  // Cycles the low fault pin is driven
    logic [7:0]  cmdRun_q;   // Cycles the low command stayed high
    // Hold time of the low fault pin
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            holdCnt_q <= 32'h0;
        else if (!lowFaultNOe)
            holdCnt_q <= 32'h0;
        else if (holdCnt_q < LATCH_CYC)
            holdCnt_q <= holdCnt_q + 32'h1;
    // Run length of the low command, saturating
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            cmdRun_q <= 8'h0;
        else if (!low_cmd_in)
            cmdRun_q <= 8'h0;
        else if (cmdRun_q != 8'hFF)
            cmdRun_q <= cmdRun_q + 8'h1;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_prim_shut_off: assert property (
        primUndervoltageLockout || !primPowerGood |-> ##2 lowFaultNOe
        && highFaultNOe && !converterEnable && !low_gate_out
        && !high_gate_out) else $error("primary fault not applied");
    chk_low_src_fault: assert property (
        lowUndervoltageLockout || !lowPowerGood |-> ##2 lowFaultNOe
        && lowSoftOff && !low_gate_out) else $error("low fault missed");
    chk_pin_level: assert property (
        lowFaultNOut == !lowFaultNOe && highFaultNOut == !highFaultNOe)
        else $error("fault pin value and drive disagree");
    chk_fault_led: assert property (
        lowFaultNOe || highFaultNOe |-> fault_indicator)
        else $error("fault indicator off during fault");
    chk_power_led: assert property (
        $past(rst_n) |-> power_indicator) else $error("power led off");
    chk_latch_hold: assert property (
        lowFaultNOe && holdCnt_q < LATCH_CYC - 1 |=> lowFaultNOe)
        else $error("low fault released early");
    chk_gates_apart: assert property (
        !(low_gate_out && high_gate_out)) else $error("both gates on");
    chk_soft_gate_off: assert property (
        !(lowSoftOff && low_gate_out) && !(highSoftOff && high_gate_out))
        else $error("gate on during soft shutdown");
    chk_turn_on_delay: assert property (
        !mode_strap && $rose(low_gate_out) |->
        cmdRun_q >= GLITCH_CYC + NOV_CYC) else $error("gate rose early");
    chk_turn_off_late: assert property (
        (!mode_strap && !low_cmd_in) [*6] |-> !low_gate_out)
        else $error("low gate stayed on");
endmodule // half_bridge_gating_sva
bind half_bridge_gating half_bridge_gating_sva #(.LATCH_CYC(LATCH_CYC),
    .GLITCH_CYC(GLITCH_CYC), .NOV_CYC(NOV_CYC)) u_half_bridge_gating_sva (
    .clk, .rst_n, .low_cmd_in, .mode_strap, .primUndervoltageLockout,
    .primPowerGood, .lowUndervoltageLockout, .lowPowerGood,
    .low_gate_out, .high_gate_out, .lowSoftOff, .highSoftOff,
    .lowFaultNOut, .lowFaultNOe, .highFaultNOut, .highFaultNOe,
    .converterEnable, .power_indicator, .fault_indicator);

/* half_bridge_gating_test.sv */
// Self-checking bench of the half-bridge gating block
`timescale 1ns/1ps
module half_bridge_gating_test;
    localparam int unsigned LATCH = 200;  // Shortened fault hold
    logic clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, mode_strap = 1'b0;
    logic low_cmd_in, high_cmd_in, lowFaultNIn, highFaultNIn;
    logic primUndervoltageLockout = 1'b0, primPowerGood = 1'b1;
    logic lowUndervoltageLockout = 1'b0, lowPowerGood = 1'b1;
    logic low_drain_sense = 1'b0, highUndervoltageLockout = 1'b0;
    logic highPowerGood = 1'b1, highDrainSense = 1'b0;
    logic low_gate_out, high_gate_out, lowSoftOff, highSoftOff;
    logic lowFaultNOut, lowFaultNOe, highFaultNOut, highFaultNOe;
    logic converterEnable, power_indicator, fault_indicator;
    logic lowReq = 1'b0, highReq = 1'b0, overlap = 1'b0, chkStb = 1'b0;
    logic [7:0] notes[$];     // Expected output snapshots
    logic [7:0] rnd = 8'h13;  // Random state
    int mismatches = 0, checks_done = 0;
    wire [7:0] seen = {low_gate_out, high_gate_out, lowSoftOff,
        highSoftOff, lowFaultNIn, highFaultNIn, converterEnable,
        fault_indicator};
    half_bridge_gating #(.LATCH_CYC(LATCH), .GLITCH_CYC(3), .AOV_CYC(8),
        .NOV_CYC(4), .BLANK_CYC(6)) u_half_bridge_gating (
        .clk, .rst_n, .clkEn, .low_cmd_in, .high_cmd_in,
        .primUndervoltageLockout, .primPowerGood, .lowUndervoltageLockout,
        .lowPowerGood, .low_drain_sense, .highUndervoltageLockout,
        .highPowerGood, .highDrainSense, .mode_strap, .lowFaultNIn,
        .highFaultNIn, .low_gate_out, .high_gate_out, .lowSoftOff,
        .highSoftOff, .lowFaultNOut, .lowFaultNOe, .highFaultNOut,
        .highFaultNOe, .converterEnable, .power_indicator,
        .fault_indicator);
    pwm_ctrl_model u_pwm_ctrl_model (.clk, .rst_n, .lowReq, .highReq,
        .overlap, .lowFaultNOe, .lowFaultNOut, .highFaultNOe,
        .highFaultNOut, .low_cmd_in, .high_cmd_in, .lowPin(lowFaultNIn),
        .highPin(highFaultNIn));
    // Clock, 4 ns period
    always #2 clk = ~clk;
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Queue one expected snapshot for the watcher
    task automatic note(input logic [7:0] e);
        notes.push_back(e);
        chkStb <= 1'b1;
        @(posedge clk);
        chkStb <= 1'b0;
    endtask
    task automatic cmp(input string nm, input logic [7:0] e,
                       input logic [7:0] s);
        checks_done++;
        if (s !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic stop_test;
        if (mismatches == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Watcher compares settled outputs with the oldest note
    always @(negedge clk)
        if (chkStb && notes.size() > 0)
            cmp("outputs", notes.pop_front(), seen);
    // Watchdog
    initial
    begin
        #40000;
        mismatches++;
        stop_test();
    end
    // Main sequence
    initial
    begin
        cyc(3);
        rst_n <= 1'b1;
        cyc(4);
        note(8'h0E);
        repeat (3)
        begin
            rnd = lfsr(rnd);
            lowReq <= 1'b1;
            cyc(16 + int'(rnd[3:0]));
            note(8'h8E);
            lowReq <= 1'b0;
            cyc(12);
            note(8'h0E);
        end
        highReq <= 1'b1;
        cyc(20);
        note(8'h4E);
        highReq <= 1'b0;
        cyc(12);
        lowReq <= 1'b1;
        cyc(2);
        lowReq <= 1'b0;
        cyc(12);
        note(8'h0E);
        // Channel undervoltage while the low gate is on
        lowReq <= 1'b1;
        cyc(20);
        lowUndervoltageLockout <= 1'b1;
        cyc(3);
        lowUndervoltageLockout <= 1'b0;
        cyc(4);
        note(8'h27);
        cyc(100);
        note(8'h27);
        cyc(LATCH);
        note(8'h0E);
        lowReq <= 1'b0;
        cyc(10);
        lowReq <= 1'b1;
        cyc(20);
        note(8'h8E);
        // Primary regulator dip, then a lasting lockout
        primPowerGood <= 1'b0;
        cyc(3);
        primPowerGood <= 1'b1;
        cyc(4);
        note(8'h01);
        cyc(LATCH);
        note(8'h0E);
        primUndervoltageLockout <= 1'b1;
        cyc(LATCH + 20);
        note(8'h01);
        primUndervoltageLockout <= 1'b0;
        cyc(6);
        note(8'h0E);
        lowReq <= 1'b0;
        cyc(12);
        // Desaturation on the high side
        highDrainSense <= 1'b1;
        highReq <= 1'b1;
        cyc(30);
        note(8'h1B);
        highDrainSense <= 1'b0;
        highReq <= 1'b0;
        cyc(LATCH + 10);
        note(8'h0E);
        // Long overlap of both commands
        overlap <= 1'b1;
        lowReq <= 1'b1;
        highReq <= 1'b1;
        cyc(30);
        note(8'h0E);
        highReq <= 1'b0;
        cyc(20);
        note(8'h8E);
        lowReq <= 1'b0;
        cyc(12);
        note(8'h0E);
        // Local mode after a second reset
        rst_n <= 1'b0;
        mode_strap <= 1'b1;
        lowReq <= 1'b1;
        cyc(3);
        rst_n <= 1'b1;
        cyc(6);
        note(8'h0E);
        highReq <= 1'b1;
        cyc(20);
        note(8'h4E);
        highReq <= 1'b0;
        lowReq <= 1'b0;
        cyc(20);
        clkEn <= 1'b0;
        highReq <= 1'b1;
        cyc(20);
        note(8'h8E);
        stop_test();
    end
endmodule // half_bridge_gating_test

/* half_bridge_map.svh */
// Constants and timing counts of the half-bridge fault and PWM gating block
// What this block does
// - Primary fault: input lockout OR regulator not good
// - Every combined fault held latched 14 ms
// - Primary latched: fault pins low, gates off
// - Source still present: stay faulted until cleared
// - Primary clears: PWM resumes on next rising edge
// - Each fault pin: primary OR own channel fault
// - Channel fault: lockout, regulator or desaturation trip
// - Channel fault: gate off, soft shutdown on entry
// - Channel clears: resume on next command rising edge
// - Power indicator on, fault indicator on any fault
// - Direct mode: two filtered inputs, controller spaces them
// - Local mode: both gates from filtered high input
// - Local mode: low gate on while high input low
// - Direct complementary: dead time; both low: gates low
// - Strap absent direct, strap installed local mode
// - Local dead time 5.5 ns per pF setting
// - Gates follow command edges after short delay
// - Desaturation after blanking: soft off, fault pin low
// - Channel undervoltage: soft off, fault pin low
// - Pulses shorter than filter width ignored, delayed
// - Direct mode, both inputs long active: gates low until release
`ifndef HALF_BRIDGE_MAP_SVH
`define HALF_BRIDGE_MAP_SVH
`define HB_CLK_MHZ        250
`define HB_LATCH_MS       14
`define HB_LATCH_CYC      (`HB_LATCH_MS * 1000 * `HB_CLK_MHZ)
`define HB_LATCH_W        22
`define HB_GLITCH_NS      50
`define HB_GLITCH_CYC     ((`HB_GLITCH_NS * `HB_CLK_MHZ + 999) / 1000)
`define HB_AOV_NS         200
`define HB_AOV_CYC        ((`HB_AOV_NS * `HB_CLK_MHZ + 999) / 1000)
`define HB_NOV_PS_PER_PF  5500
`define HB_NOVD_PF        10
`define HB_NOV_CYC        ((`HB_NOV_PS_PER_PF * `HB_NOVD_PF * `HB_CLK_MHZ \
                            + 999999) / 1000000)
`define HB_BLANK_PF       68
`define HB_BLANK_NS       (14 * (`HB_BLANK_PF + 7))
`define HB_BLANK_CYC      ((`HB_BLANK_NS * `HB_CLK_MHZ + 999) / 1000)
`endif

/* half_bridge_pkg.sv */
// Types shared by the half-bridge gating modules
package half_bridge_pkg;
    // Operating mode chosen by the strap
    typedef enum logic {
        MODE_DIRECT = 1'b0,
        MODE_LOCAL  = 1'b1
    } mode_e;
    // Per-channel gating state
    typedef enum logic [1:0] {
        CH_BLOCKED = 2'b00,
        CH_RUN     = 2'b01,
        CH_SOFT    = 2'b10
    } ch_state_e;
endpackage

/* pwm_ctrl_model.sv */
// Controller model: PWM commands out, pulled-up fault pins read back
`timescale 1ns/1ps
module pwm_ctrl_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic lowReq,        // Wanted low-side state
    input  wire logic highReq,       // Wanted high-side state
    input  wire logic overlap,       // Lets both commands stand together
    input  wire logic lowFaultNOe,
    input  wire logic lowFaultNOut,
    input  wire logic highFaultNOe,
    input  wire logic highFaultNOut,
    output logic      low_cmd_in,
    output logic      high_cmd_in,
    output logic      lowPin,        // Low fault line level
    output logic      highPin        // High fault line level
);
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            low_cmd_in  <= 1'b0;
            high_cmd_in <= 1'b0;
        end
        else
        begin
            low_cmd_in  <= lowReq & (overlap | ~high_cmd_in);
            high_cmd_in <= highReq & (overlap | ~(lowReq | low_cmd_in));
        end
    // Pull-up holds a released line high
    assign lowPin  = lowFaultNOe ? lowFaultNOut : 1'b1;
    assign highPin = highFaultNOe ? highFaultNOut : 1'b1;
endmodule // pwm_ctrl_model
